// File: src/insn_class_decode_ea_gen.sv
/*
 classifies each fetched word and generates operand, branch and link addresses.
 assumes requests from same-clock fetch logic; exception logic samples the result.
*/
`timescale 1ns/100ps
module insn_class_decode_ea_gen #(
    parameter logic [1023:0] EXT19_USED = '0,
    parameter logic [1023:0] EXT31_USED = '0,
    parameter logic [1023:0] EXT59_USED = '0,
    parameter logic [1023:0] EXT63_USED = '0,
    parameter logic [63:0] RESERVED_IMPL = '0,
    parameter logic OPT_GENERAL = 1'b1,
    parameter logic OPT_GRAPHICS = 1'b1,
    parameter logic INVALID_TRAPS = 1'b1
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic little_endian_set,
    input wire logic little_endian_value,
    input wire insn_decode_pkg::decode_req_type req,
    output logic little_endian,
    output insn_decode_pkg::decode_rsp_type rsp
);
    import insn_decode_pkg::*;

    typedef struct packed {
        logic little;
        decode_rsp_type rsp;
    } state_type;

    state_type state_r;
    state_type state_nxt;

    function automatic logic ext_used(input logic [1023:0] table_bits, input logic [9:0] xo);
        ext_used = table_bits[xo];
    endfunction

    function automatic logic [31:0] add32(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        add32 = sum[31:0];
    endfunction

    // primary opcodes that never decode on this 32-bit part
    function automatic logic primary_illegal(input logic [5:0] op);
        logic future;
        logic wide;
        future = FUTURE_OPS[op];
        wide = WIDE_OPS[op];
        primary_illegal = future | wide;
    endfunction

    // unassigned extended codes; the 5-bit form covers the short arithmetic slots
    function automatic logic ext_illegal(input logic [5:0] op, input logic [9:0] xo,
        input logic [4:0] xo5);
        logic bad;
        bad = 1'b0;
        case (op)
            OP_CR_EXT:
            begin
                bad = !ext_used(EXT19_USED, xo);
            end
            OP_INT_EXT:
            begin
                bad = !ext_used(EXT31_USED, xo);
            end
            OP_FPS_EXT:
            begin
                bad = !ext_used(EXT59_USED, {5'h00, xo5});
            end
            OP_FPD_EXT:
            begin
                bad = !ext_used(EXT63_USED, xo) && !ext_used(EXT63_USED, {5'h00, xo5});
            end
            default:
            begin
                bad = 1'b0;
            end
        endcase
        ext_illegal = bad;
    endfunction

    // a category is built whole or not at all, so one switch gates every member
    function automatic logic option_absent(input logic [5:0] op, input logic [4:0] xo5);
        logic general;
        logic graphics;
        general = (op == OP_FPS_EXT || op == OP_FPD_EXT) && xo5 == XO_ROOT;
        graphics = (op == OP_FPS_EXT && xo5 == XO_RECIP) ||
            (op == OP_FPD_EXT && (xo5 == XO_SELECT || xo5 == XO_RROOT));
        option_absent = (general && !OPT_GENERAL) || (graphics && !OPT_GRAPHICS);
    endfunction

    function automatic logic zero_illegal(input logic [31:0] word);
        zero_illegal = word == 32'h0000_0000;
    endfunction

    function automatic logic zero_reserved(input logic [31:0] word);
        zero_reserved = word[31:26] == OP_ZERO && word[25:0] != 26'h0;
    endfunction

    // update forms naming the base as target are deducible from the word alone
    function automatic logic invalid_form(input logic [31:0] word);
        logic [5:0] op;
        logic [4:0] base_reg;
        logic [4:0] dest_reg;
        op = word[31:26];
        base_reg = word[20:16];
        dest_reg = word[25:21];
        invalid_form = (op == OP_LOAD_WORD_UPD || op == OP_LOAD_BYTE_UPD) &&
            (base_reg == 5'h00 || base_reg == dest_reg);
    endfunction

    function automatic logic [31:0] ls_address(input decode_req_type r);
        logic [31:0] sum;
        sum = r.base;
        if (r.ls_mode == LS_DISP)
        begin
            sum = add32(r.base, r.disp);
        end
        else if (r.ls_mode == LS_INDEX)
        begin
            sum = add32(r.base, r.index);
        end
        ls_address = sum;
    endfunction

    // little-endian munging only applies to operands shorter than a double word
    function automatic logic [31:0] swap_low(input logic [31:0] addr, input logic [31:0] len,
        input logic little);
        logic [31:0] result;
        result = addr;
        if (little && len < 32'h0000_0008)
        begin
            result[2:0] = addr[2:0] ^ (3'h7 & ~(len[2:0] - 3'h1));
        end
        swap_low = result;
    endfunction

    // register targets drop the two low bits so fetch stays word aligned
    function automatic logic [31:0] branch_target(input decode_req_type r);
        logic [31:0] dest;
        case (r.br_mode)
            BR_LINK:
            begin
                dest = {r.return_link_register[31:2], 2'b00};
            end
            BR_COUNT:
            begin
                dest = {r.loop_count_register[31:2], 2'b00};
            end
            default:
            begin
                dest = r.br_absolute ? r.disp : add32(r.insn_addr, r.disp);
            end
        endcase
        branch_target = dest;
    endfunction

    function automatic logic operand_wraps(input logic [31:0] addr, input logic [31:0] len);
        logic [32:0] last;
        last = {1'b0, addr} + {1'b0, len} - 33'h1;
        operand_wraps = len != 32'h0 && last > 33'h0_FFFF_FFFF;
    endfunction

    // non-power-of-two lengths have no natural boundary, so they count as misaligned
    function automatic logic operand_misaligned(input logic [31:0] addr, input logic [31:0] len);
        logic off_boundary;
        logic odd_length;
        off_boundary = (addr & (len - 32'h1)) != 32'h0;
        odd_length = (len & (len - 32'h1)) != 32'h0;
        operand_misaligned = len != 32'h0 && (off_boundary || odd_length);
    endfunction

    // only flagged here; the extra cycles are spent by the pipeline
    function automatic logic slow_encoding(input logic [31:0] word);
        logic [5:0] op;
        op = word[31:26];
        slow_encoding = (op == OP_OR_IMM && word[25:0] != 26'h0) ||
            ((op == OP_LOAD_MULTI || op == OP_STORE_MULTI) && word[20:16] == 5'h00);
    endfunction

    // illegal outranks reserved, which outranks an invalid form
    function automatic insn_class_type class_of(input logic ill, input logic rsv, input logic inv);
        insn_class_type c;
        if (ill)
        begin
            c = CLASS_ILLEGAL;
        end
        else if (rsv)
        begin
            c = CLASS_RESERVED;
        end
        else if (inv)
        begin
            c = CLASS_INVALID;
        end
        else
        begin
            c = CLASS_DEFINED;
        end
        class_of = c;
    endfunction

    // return address is the next sequential word, wrapping at the top
    function automatic logic [31:0] next_sequential(input logic [31:0] addr);
        next_sequential = add32(addr, INSN_BYTES);
    endfunction

    function automatic logic fetch_unaligned(input logic [31:0] addr);
        fetch_unaligned = addr[1:0] != 2'b00;
    endfunction

    always_comb
    begin
        logic [5:0] op;
        logic [9:0] xo;
        logic [4:0] xo5;
        logic ill;
        logic rsv;
        logic inv;
        logic trap;
        logic [31:0] oper_addr;
        logic [31:0] target;
        logic [31:0] len;
        op = req.word[31:26];
        xo = req.word[10:1];
        xo5 = req.word[5:1];
        len = {28'h0000000, req.length};
        state_nxt = state_r;
        if (little_endian_set)
        begin
            state_nxt.little = little_endian_value;
        end
        ill = 1'b0;
        if (primary_illegal(op))
        begin
            ill = 1'b1;
        end
        if (ext_illegal(op, xo, xo5))
        begin
            ill = 1'b1;
        end
        if (option_absent(op, xo5))
        begin
            ill = 1'b1;
        end
        if (zero_illegal(req.word))
        begin
            ill = 1'b1;
        end
        rsv = zero_reserved(req.word);
        inv = invalid_form(req.word);
        trap = 1'b0;
        if (ill || (rsv && !RESERVED_IMPL[op]) || (inv && INVALID_TRAPS))
        begin
            trap = 1'b1;
        end
        else
        begin
            // an untrapped invalid form runs as defined, a legal reachable outcome
            trap = 1'b0;
        end
        oper_addr = swap_low(ls_address(req), len, state_r.little);
        if (req.is_branch)
        begin
            target = branch_target(req);
        end
        else
        begin
            target = oper_addr;
        end
        state_nxt.rsp.valid = req.valid;
        state_nxt.rsp.program_exception = req.valid && trap;
        state_nxt.rsp.insn_class = class_of(ill, rsv, inv);
        state_nxt.rsp.vector = PROGRAM_VECTOR;
        state_nxt.rsp.commit_ok = req.valid && !trap;
        state_nxt.rsp.computed_operand_address = target;
        state_nxt.rsp.last_byte_address = add32(oper_addr, len - 32'h0000_0001);
        state_nxt.rsp.wraps = !req.is_branch && operand_wraps(oper_addr, len);
        state_nxt.rsp.misaligned = !req.is_branch && operand_misaligned(oper_addr, len);
        state_nxt.rsp.fetch_misaligned = fetch_unaligned(req.insn_addr);
        state_nxt.rsp.link_valid = req.valid && req.is_branch && req.br_link && !trap;
        state_nxt.rsp.link_value = next_sequential(req.insn_addr);
        state_nxt.rsp.slow_form = slow_encoding(req.word);
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= '0;
            state_r.little <= LITTLE_RESET;
            state_r.rsp.insn_class <= CLASS_DEFINED;
            state_r.rsp.vector <= PROGRAM_VECTOR;
            state_r.rsp.computed_operand_address <= ADDR_RESET;
        end
        else if (clock_enable)
        begin
            state_r <= state_nxt;
        end
    end

    assign little_endian = state_r.little;
    assign rsp = state_r.rsp;
endmodule

// File: include/insn_decode_pkg.sv
/*
 instruction classification and address generation constants and carriers.
 assumes a 32-bit implementation, one clock, fetch and exception logic outside.
*/
// Summary of operation
// - reserved-future primary opcodes decode as illegal
// - 64-bit-only primary opcodes illegal here
// - unassigned extended opcodes are illegal
// - all-zero word is always illegal
// - opcode zero with other bits is reserved
// - unimplemented reserved instruction raises illegal exception
// - illegal raises program exception, no other effect
// - absent optional instruction raises illegal exception
// - optional categories all-or-nothing
// - invalid form raises illegal or bounded result
// - bounded results reachable by some instruction sequence
// - unimplemented defined instruction may trap for emulation
// - non-preferred forms may run slower
// - operand address is its lowest byte
// - aligned only when address multiple of length
// - big-endian after reset, little-endian optional
// - 32-bit address sum, carry discarded
// - operand wraps past top through zero
// - little-endian mode may alter three low bits
// - three load/store address modes
// - three branch target modes
// - link loads current address plus four
// - instructions are four-byte word aligned
package insn_decode_pkg;
    localparam logic [5:0] OP_ZERO = 6'h00;
    localparam logic [5:0] OP_CR_EXT = 6'h13;
    localparam logic [5:0] OP_INT_EXT = 6'h1F;
    localparam logic [5:0] OP_FPS_EXT = 6'h3B;
    localparam logic [5:0] OP_FPD_EXT = 6'h3F;
    localparam logic [5:0] OP_OR_IMM = 6'h18;
    localparam logic [5:0] OP_LOAD_WORD_UPD = 6'h21;
    localparam logic [5:0] OP_LOAD_BYTE_UPD = 6'h23;
    localparam logic [5:0] OP_LOAD_MULTI = 6'h2E;
    localparam logic [5:0] OP_STORE_MULTI = 6'h2F;
    localparam logic [4:0] XO_ROOT = 5'h16;
    localparam logic [4:0] XO_SELECT = 5'h17;
    localparam logic [4:0] XO_RECIP = 5'h18;
    localparam logic [4:0] XO_RROOT = 5'h1A;
    localparam logic [63:0] FUTURE_OPS = 64'h3300_0000_0000_0072;
    localparam logic [63:0] WIDE_OPS = 64'h4400_0000_4000_0004;
    localparam logic [31:0] PROGRAM_VECTOR = 32'h0000_0700;
    localparam logic [31:0] INSN_BYTES = 32'h0000_0004;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic LITTLE_RESET = 1'b0;

    typedef enum logic [3:0] {
        CLASS_DEFINED = 4'b0001,
        CLASS_ILLEGAL = 4'b0010,
        CLASS_RESERVED = 4'b0100,
        CLASS_INVALID = 4'b1000
    } insn_class_type;

    typedef enum logic [2:0] {
        LS_DISP = 3'b001,
        LS_INDEX = 3'b010,
        LS_INDIRECT = 3'b100
    } ls_mode_type;

    typedef enum logic [2:0] {
        BR_IMM = 3'b001,
        BR_LINK = 3'b010,
        BR_COUNT = 3'b100
    } br_mode_type;

    typedef struct packed {
        logic valid;
        logic [31:0] word;
        logic [31:0] insn_addr;
        logic is_branch;
        br_mode_type br_mode;
        logic br_absolute;
        logic br_link;
        ls_mode_type ls_mode;
        logic [31:0] base;
        logic [31:0] index;
        logic [31:0] disp;
        logic [3:0] length;
        logic [31:0] return_link_register;
        logic [31:0] loop_count_register;
    } decode_req_type;

    typedef struct packed {
        logic valid;
        insn_class_type insn_class;
        logic program_exception;
        logic [31:0] vector;
        logic commit_ok;
        logic [31:0] computed_operand_address;
        logic [31:0] last_byte_address;
        logic wraps;
        logic misaligned;
        logic fetch_misaligned;
        logic link_valid;
        logic [31:0] link_value;
        logic slow_form;
    } decode_rsp_type;
endpackage

// File: dv/insn_decode_properties.sv
/*
 checker for classification, address and link outputs of the decoder.
 assumes default parameters, so every reserved word traps.
*/
`timescale 1ns/100ps
module insn_decode_properties
import insn_decode_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic little_endian_set,
    input wire logic little_endian_value,
    input wire decode_req_type req,
    input wire logic little_endian,
    input wire decode_rsp_type rsp
);
    logic take;
    logic [31:0] index_sum;
    logic [31:0] link_sum;
    assign take = clock_enable && req.valid;
    assign index_sum = req.base + req.index;
    assign link_sum = req.insn_addr + INSN_BYTES;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_zero_illegal: assert property (
        take && req.word == 32'h0 |=> rsp.insn_class == CLASS_ILLEGAL) else $error("zero word");
    a_future_illegal: assert property (
        take && FUTURE_OPS[req.word[31:26]] |=> rsp.insn_class == CLASS_ILLEGAL)
        else $error("future opcode");
    a_wide_illegal: assert property (
        take && WIDE_OPS[req.word[31:26]] |=> rsp.insn_class == CLASS_ILLEGAL)
        else $error("wide opcode");
    a_reserved_traps: assert property (
        take && req.word[31:26] == OP_ZERO && req.word[25:0] != 26'h0
        |=> rsp.insn_class == CLASS_RESERVED && rsp.program_exception) else $error("reserved");
    a_illegal_no_commit: assert property (
        rsp.valid && rsp.insn_class == CLASS_ILLEGAL
        |-> rsp.program_exception && !rsp.commit_ok && rsp.vector == PROGRAM_VECTOR)
        else $error("illegal committed");
    a_index_sum_wraps: assert property (
        take && !req.is_branch && req.ls_mode == LS_INDEX && !little_endian
        |=> rsp.computed_operand_address == $past(index_sum)) else $error("index sum");
    a_link_plus_four: assert property (
        take && req.is_branch && req.br_link && req.word[31:26] == 6'h12
        |=> rsp.link_valid && rsp.link_value == $past(link_sum)) else $error("link value");
    a_mode_load: assert property (
        clock_enable && little_endian_set |=> little_endian == $past(little_endian_value))
        else $error("mode load");
    a_mode_reset: assert property (
        $rose(reset_n) |-> !little_endian) else $error("mode after reset");
endmodule
bind insn_class_decode_ea_gen insn_decode_properties u_insn_decode_properties (.clock(clock),
    .reset_n(reset_n), .clock_enable(clock_enable), .little_endian_set(little_endian_set),
    .little_endian_value(little_endian_value), .req(req), .little_endian(little_endian),
    .rsp(rsp));

// File: dv/fetch_model.sv
/*
 fetch side model: presents one word per call, then releases the request.
 assumes the decoder answers on the same edge that takes the word.
*/
`timescale 1ns/100ps
module fetch_model
import insn_decode_pkg::*;
(
    input wire logic clock,
    output decode_req_type req
);
    initial req = '0;
    // released fields show the inverse so stale values cannot pass a check
    task automatic issue(input decode_req_type r);
        @(posedge clock);
        req <= r;
        @(posedge clock);
        req <= decode_req_type'({1'b0, ~r[$bits(r)-2:0]});
        #1;
    endtask
endmodule

// File: dv/insn_class_decode_ea_gen_test.sv
/*
 self-checking bench for the decoder with default parameters.
 assumes the fetch model in its own file and the bound checker.
*/
`timescale 1ns/100ps
module insn_class_decode_ea_gen_test;
    import insn_decode_pkg::*;
    logic clock;
    logic reset_n;
    logic clock_enable;
    logic little_endian_set;
    logic little_endian_value;
    logic little_endian;
    decode_req_type req;
    decode_rsp_type rsp;
    decode_req_type r;
    int n_fail;
    int checks;
    int cycles;
    insn_class_decode_ea_gen u_insn_class_decode_ea_gen (.clock(clock), .reset_n(reset_n),
        .clock_enable(clock_enable), .little_endian_set(little_endian_set),
        .little_endian_value(little_endian_value), .req(req), .little_endian(little_endian),
        .rsp(rsp));
    fetch_model u_fetch_model (.clock(clock), .req(req));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic decode_req_type plain(input logic [31:0] word);
        plain = '0;
        plain.valid = 1'b1;
        plain.word = word;
        plain.br_mode = BR_IMM;
        plain.ls_mode = LS_DISP;
        plain.length = 4'h4;
    endfunction
    task automatic expect_class(input logic [31:0] word, input insn_class_type c, input logic e);
        u_fetch_model.issue(plain(word));
        check("class", 32'(c), 32'(rsp.insn_class));
        check("exception", 32'(e), 32'(rsp.program_exception));
        check("commit", 32'(!e), 32'(rsp.commit_ok));
        check("vector", PROGRAM_VECTOR, rsp.vector);
        check("valid", 32'h1, 32'(rsp.valid));
    endtask
    task automatic test_classes;
        logic [5:0] ill [12] = '{6'h01, 6'h04, 6'h05, 6'h06, 6'h38, 6'h39, 6'h3C, 6'h3D,
            6'h02, 6'h1E, 6'h3A, 6'h3E};
        for (int i = 0; i < 12; i++)
            expect_class({ill[i], 26'h0}, CLASS_ILLEGAL, 1'b1);
        expect_class(32'h0, CLASS_ILLEGAL, 1'b1);
        expect_class(32'h0000_0001, CLASS_RESERVED, 1'b1);
        expect_class(32'h7C00_0214, CLASS_ILLEGAL, 1'b1);
        expect_class(32'h8400_0000, CLASS_INVALID, 1'b1);
        expect_class(32'h3800_0000, CLASS_DEFINED, 1'b0);
        u_fetch_model.issue(plain(32'h6000_0001));
        check("slow form", 32'h1, 32'(rsp.slow_form));
        u_fetch_model.issue(plain(32'h6000_0000));
        check("preferred form", 32'h0, 32'(rsp.slow_form));
        $display("test classes done");
    endtask
    task automatic test_address;
        r = plain(32'h8000_0000);
        r.ls_mode = LS_INDEX;
        r.base = 32'hFFFF_FFFC;
        r.index = 32'h8;
        u_fetch_model.issue(r);
        check("index address", 32'h4, rsp.computed_operand_address);
        check("aligned", 32'h0, 32'(rsp.misaligned));
        r.ls_mode = LS_DISP;
        r.base = 32'h100;
        r.disp = 32'h2;
        u_fetch_model.issue(r);
        check("disp address", 32'h102, rsp.computed_operand_address);
        check("misaligned", 32'h1, 32'(rsp.misaligned));
        r.ls_mode = LS_INDIRECT;
        r.base = 32'hFFFF_FFFE;
        r.insn_addr = 32'h2;
        u_fetch_model.issue(r);
        check("indirect address", 32'hFFFF_FFFE, rsp.computed_operand_address);
        check("wraps", 32'h1, 32'(rsp.wraps));
        check("last byte", 32'h1, rsp.last_byte_address);
        check("fetch align", 32'h1, 32'(rsp.fetch_misaligned));
        $display("test address done");
    endtask
    task automatic test_branch;
        r = plain(32'h4800_0001);
        r.is_branch = 1'b1;
        r.br_mode = BR_LINK;
        r.br_link = 1'b1;
        r.insn_addr = 32'h1000;
        r.return_link_register = 32'h2003;
        u_fetch_model.issue(r);
        check("link target", 32'h2000, rsp.computed_operand_address);
        check("link value", 32'h1004, rsp.link_value);
        r.br_mode = BR_COUNT;
        r.br_link = 1'b0;
        r.loop_count_register = 32'h3000;
        u_fetch_model.issue(r);
        check("count target", 32'h3000, rsp.computed_operand_address);
        check("no link", 32'h0, 32'(rsp.link_valid));
        r.br_mode = BR_IMM;
        r.insn_addr = 32'hFFFF_FFFC;
        r.disp = 32'h8;
        u_fetch_model.issue(r);
        check("imm target", 32'h4, rsp.computed_operand_address);
        $display("test branch done");
    endtask
    task automatic set_mode(input logic v);
        @(posedge clock);
        little_endian_set <= 1'b1;
        little_endian_value <= v;
        @(posedge clock);
        little_endian_set <= 1'b0;
        #1;
        check("mode", 32'(v), 32'(little_endian));
    endtask
    task automatic test_endian;
        check("reset mode", 32'h0, 32'(little_endian));
        set_mode(1'b1);
        r = plain(32'h8800_0000);
        r.base = 32'h100;
        r.length = 4'h1;
        u_fetch_model.issue(r);
        check("swapped address", 32'h107, rsp.computed_operand_address);
        set_mode(1'b0);
        $display("test endian done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    initial
    begin
        reset_n = 1'b0;
        clock_enable = 1'b1;
        little_endian_set = 1'b0;
        little_endian_value = 1'b0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        test_endian();
        test_classes();
        test_address();
        test_branch();
        end_of_test();
    end
endmodule
